// [hdl/sss_pkg.sv]
// constants, register map and types of the start-up delay and soft-start sequencer
// Functional notes
// - hold enable line low until ready
// - every sharer holds line low independently
// - count turn-on delay after line release
// - shared timebase, fastest device sets ticks
// - ramp target from zero to setpoint
// - skip ramp when rise below 0.25 ms
// - one step per 0.1 ms tick
// - force discontinuous mode during ramp
// - reverse current cuts bottom gate in discontinuous
// - gpio releases when output above undervoltage limit
// - propagate bit selects deglitched undervoltage signal
// - deglitch filter of 70 us
// - effective rise time capped at 1.3 s
// - after ramp and undervoltage clear, programmed mode
package sss_pkg;

  // clock and timing, times in ns
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TIMEBASE_NS = 100000; // one timebase tick, 0.1 ms
  localparam int unsigned UV_FILTER_NS = 70000; // undervoltage deglitch, 70 us
  localparam int unsigned TIMEBASE_CYC = TIMEBASE_NS / CLK_PERIOD_NS;
  localparam int unsigned UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // time registers count in 10 us units
  localparam logic [17:0] TICK_UNITS = 18'h0000a; // 0.1 ms per tick
  localparam logic [17:0] SOFTSTART_MIN_UNITS = 18'h00019; // 0.250 ms
  localparam logic [17:0] RISE_CAP_UNITS = 18'h1fbd0; // 1.3 s

  // register byte offsets
  localparam logic [7:0] OFS_OP_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PIN_PROPAGATE = 8'h04;
  localparam logic [7:0] OFS_VIN_THRESHOLD = 8'h08;
  localparam logic [7:0] OFS_TURN_ON_DELAY = 8'h0c;
  localparam logic [7:0] OFS_RISE_TIME = 8'h10;
  localparam logic [7:0] OFS_UV_LIMIT = 8'h14;
  localparam logic [7:0] OFS_SETPOINT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // field positions
  localparam int unsigned PROP_UV_RELEASE_BIT = 0;
  localparam int unsigned PROP_DEGLITCH_BIT = 1;
  localparam int unsigned STAT_RUN_BIT = 4;
  localparam int unsigned STAT_UV_OK_BIT = 5;
  localparam int unsigned STAT_DCM_BIT = 6;
  localparam int unsigned STAT_TARGET_LSB = 16;

  // reset values
  localparam logic [1:0] RST_OP_MODE = 2'h0;
  localparam logic [1:0] RST_PIN_PROPAGATE = 2'h0;
  localparam logic [15:0] RST_VIN_THRESHOLD = 16'h0000;
  localparam logic [17:0] RST_TURN_ON_DELAY = 18'h00000;
  localparam logic [17:0] RST_RISE_TIME = 18'h00000;
  localparam logic [15:0] RST_UV_LIMIT = 16'h0000;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;

  // switching stage modes
  localparam logic [1:0] MODE_FORCED_CONT = 2'h0;
  localparam logic [1:0] MODE_DCM = 2'h1;
  localparam logic [1:0] MODE_LIGHT_LOAD = 2'h2;

  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_RELEASE = 3'b001,
    ST_DELAY = 3'b010,
    ST_DIVN = 3'b011,
    ST_DIVQ = 3'b100,
    ST_RAMP = 3'b101,
    ST_SETTLE = 3'b110,
    ST_ON = 3'b111
  } sss_state_t;

endpackage : sss_pkg

// [hdl/sss_uv_deglitch.sv]
// digital deglitch filter for the output undervoltage comparison
`timescale 1ns/1ps
module sss_uv_deglitch #(
  parameter int unsigned FILT_CYCLES = 8750
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic raw_in,
  output logic filt_out
);

  localparam int unsigned CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYCLES - 1);

  logic filt_q; // filtered level
  logic filt_d;
  logic [CW-1:0] cnt_q; // cycles the raw level has disagreed
  logic [CW-1:0] cnt_d;

  // a disagreement must persist the whole window before it is taken
  always_comb begin
    filt_d = filt_q;
    cnt_d = '0;
    if (raw_in != filt_q) begin
      if (cnt_q == LAST) begin
        filt_d = raw_in;
      end else begin
        cnt_d = cnt_q + 1'b1; // chatter restarts the count
      end
    end
  end

  // register the filter state
  always_ff @(posedge mclk) begin
    if (reset) begin
      filt_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      filt_q <= filt_d;
      cnt_q <= cnt_d;
    end
  end

  assign filt_out = filt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_filt_hold_short: assert property ((raw_in != filt_q) && (cnt_q != LAST) |=> $stable(filt_q))
    else $error("filter output moved before window elapsed");
  a_filt_take_long: assert property ((raw_in != filt_q) && (cnt_q == LAST) |=> filt_q == $past(raw_in))
    else $error("filter output did not follow after window");

endmodule : sss_uv_deglitch

// [hdl/sss_sequencer.sv]
// start-up sequencer: enable line hold, turn-on delay, soft-start ramp, gpio release
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sss_sequencer
  import sss_pkg::*;
#(
  parameter int unsigned TIMEBASE_CYCLES = TIMEBASE_CYC,
  parameter int unsigned UV_FILTER_CYCLES = UV_FILTER_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic init_done,
  input wire logic [15:0] vin_level,
  input wire logic [15:0] vout_level,
  input wire logic run_in,
  output logic run_out,
  output logic run_oe,
  input wire logic timebase_in,
  output logic timebase_out,
  output logic timebase_oe,
  input wire logic reverse_current_in,
  output logic gpio_out,
  output logic gpio_oe,
  output logic [15:0] target_level,
  output logic [1:0] pwm_mode,
  output logic bottom_gate_allow,
  output logic switching_en
);

  localparam logic [15:0] TB_LAST = 16'(TIMEBASE_CYCLES - 1);
  localparam logic [15:0] TB_HALF = 16'(TIMEBASE_CYCLES / 2);

  // software registers
  logic [1:0] op_mode_q; // programmed operating mode
  logic [1:0] prop_q; // pin_propagate_config
  logic [15:0] vin_thr_q; // input_turn_on_threshold
  logic [17:0] turn_on_delay_q; // turn_on_delay, 10 us units
  logic [17:0] rise_q; // output_rise_time, 10 us units
  logic [15:0] uv_limit_q; // output_undervoltage_limit
  logic [15:0] setpoint_q; // commanded output level
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // pin synchronisers, first stages read only by second stages
  logic run_s1_q, run_s2_q;
  logic tb_s1_q, tb_s2_q, tb_s3_q;
  logic rev_s1_q, rev_s2_q;

  // timebase
  logic [15:0] tb_cnt_q;
  logic [15:0] tb_cnt_d;
  logic tb_oe_q;
  logic tb_oe_d;
  logic tick; // falling edge of the shared timebase

  // sequencer
  sss_state_t st_q, st_d;
  logic [17:0] dly_q, dly_d; // remaining delay
  logic [17:0] num_q, num_d; // divider numerator shift
  logic [17:0] den_q, den_d;
  logic [17:0] quo_q, quo_d;
  logic [17:0] rem_q, rem_d;
  logic [4:0] dcnt_q, dcnt_d; // divider step count
  logic [13:0] nsteps_q, nsteps_d; // increments in the ramp
  logic [13:0] left_q, left_d; // increments still to go
  logic [15:0] inc_q, inc_d; // whole part of one increment
  logic [13:0] frac_q, frac_d; // leftover spread over steps
  logic [14:0] err_q, err_d;
  logic [15:0] target_q, target_d;
  logic [17:0] rise_eff;
  logic [17:0] dsh;
  logic [14:0] esum;

  // outputs and status
  logic uv_raw_q;
  logic uv_filt;
  logic uv_src;
  logic dcm_force;
  logic dcm_now;
  logic run_oe_q, gpio_oe_q, bg_q, sw_q;
  logic [1:0] pwm_q;

  // synchronise the pins onto mclk
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      tb_s1_q <= 1'b1;
      tb_s2_q <= 1'b1;
      tb_s3_q <= 1'b1;
      rev_s1_q <= 1'b0;
      rev_s2_q <= 1'b0;
    end else begin
      run_s1_q <= run_in;
      run_s2_q <= run_s1_q;
      tb_s1_q <= timebase_in;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
      rev_s1_q <= reverse_current_in;
      rev_s2_q <= rev_s1_q;
    end
  end

  // any device pulling the line low restarts our period, so the fastest rules
  assign tick = tb_s3_q & ~tb_s2_q;

  // own timebase generator, open drain low for the first half period
  always_comb begin
    if (tick) begin
      tb_cnt_d = 16'h0000;
    end else if (tb_cnt_q == TB_LAST) begin
      tb_cnt_d = 16'h0000;
    end else begin
      tb_cnt_d = tb_cnt_q + 16'h0001;
    end
    tb_oe_d = (tb_cnt_d < TB_HALF);
  end

  // register the timebase
  always_ff @(posedge mclk) begin
    if (reset) begin
      tb_cnt_q <= 16'h0000;
      tb_oe_q <= 1'b0;
    end else begin
      tb_cnt_q <= tb_cnt_d;
      tb_oe_q <= tb_oe_d;
    end
  end

  // register bus: writes steer the sequencer, reads answer next cycle only
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_OP_CONFIG: rdata_d[1:0] = op_mode_q;
        OFS_PIN_PROPAGATE: rdata_d[1:0] = prop_q;
        OFS_VIN_THRESHOLD: rdata_d[15:0] = vin_thr_q;
        OFS_TURN_ON_DELAY: rdata_d[17:0] = turn_on_delay_q;
        OFS_RISE_TIME: rdata_d[17:0] = rise_q;
        OFS_UV_LIMIT: rdata_d[15:0] = uv_limit_q;
        OFS_SETPOINT: rdata_d[15:0] = setpoint_q;
        OFS_STATUS: begin
          rdata_d[2:0] = st_q;
          rdata_d[STAT_RUN_BIT] = run_s2_q;
          rdata_d[STAT_UV_OK_BIT] = uv_src;
          rdata_d[STAT_DCM_BIT] = dcm_force;
          rdata_d[STAT_TARGET_LSB +: 16] = target_q;
        end
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // register file storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_mode_q <= RST_OP_MODE;
      prop_q <= RST_PIN_PROPAGATE;
      vin_thr_q <= RST_VIN_THRESHOLD;
      turn_on_delay_q <= RST_TURN_ON_DELAY;
      rise_q <= RST_RISE_TIME;
      uv_limit_q <= RST_UV_LIMIT;
      setpoint_q <= RST_SETPOINT;
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
      if (reg_wr) begin
        case (reg_addr)
          OFS_OP_CONFIG: op_mode_q <= reg_wdata[1:0];
          OFS_PIN_PROPAGATE: prop_q <= reg_wdata[1:0];
          OFS_VIN_THRESHOLD: vin_thr_q <= reg_wdata[15:0];
          OFS_TURN_ON_DELAY: turn_on_delay_q <= reg_wdata[17:0];
          OFS_RISE_TIME: rise_q <= reg_wdata[17:0];
          OFS_UV_LIMIT: uv_limit_q <= reg_wdata[15:0];
          OFS_SETPOINT: setpoint_q <= reg_wdata[15:0];
          default: ; // status and unmapped writes ignored
        endcase
      end
    end
  end

  // longer programmed rise times are clipped
  assign rise_eff = (rise_q > RISE_CAP_UNITS) ? RISE_CAP_UNITS : rise_q;

  // one restoring divider step, shared by both divisions
  assign dsh = {rem_q[16:0], num_q[17]};
  assign esum = err_q + {1'b0, frac_q};

  // sequencer next state
  always_comb begin
    st_d = st_q;
    dly_d = dly_q;
    num_d = num_q;
    den_d = den_q;
    quo_d = quo_q;
    rem_d = rem_q;
    dcnt_d = dcnt_q;
    nsteps_d = nsteps_q;
    left_d = left_q;
    inc_d = inc_q;
    frac_d = frac_q;
    err_d = err_q;
    target_d = target_q;
    if (st_q != ST_DIVN && st_q != ST_DIVQ) begin
      dcnt_d = 5'h00;
    end else begin
      num_d = {num_q[16:0], 1'b0};
      dcnt_d = dcnt_q + 5'h01;
      if (dsh >= den_q) begin
        rem_d = dsh - den_q;
        quo_d = {quo_q[16:0], 1'b1};
      end else begin
        rem_d = dsh;
        quo_d = {quo_q[16:0], 1'b0};
      end
    end
    case (st_q)
      ST_HOLD: begin
        target_d = 16'h0000;
        if (init_done && (vin_level > vin_thr_q)) begin
          st_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        dly_d = turn_on_delay_q;
        if (!init_done || (vin_level <= vin_thr_q)) begin
          st_d = ST_HOLD;
        end else if (run_s2_q) begin
          st_d = ST_DELAY; // every sharer has let go
        end
      end
      ST_DELAY: begin
        if (tick) begin
          if (dly_q > TICK_UNITS) begin
            dly_d = dly_q - TICK_UNITS;
          end else if (rise_eff < SOFTSTART_MIN_UNITS) begin
            target_d = setpoint_q; // no ramp at all
            st_d = ST_SETTLE;
          end else begin
            num_d = rise_eff;
            den_d = TICK_UNITS; // steps = rise / 0.1 ms
            quo_d = 18'h00000;
            rem_d = 18'h00000;
            st_d = ST_DIVN;
          end
        end
      end
      ST_DIVN: begin
        if (dcnt_q == 5'd17) begin
          dcnt_d = 5'h00; // second division needs a fresh step count
          nsteps_d = quo_d[13:0];
          num_d = {2'b00, setpoint_q};
          den_d = {4'h0, quo_d[13:0]};
          quo_d = 18'h00000;
          rem_d = 18'h00000;
          st_d = ST_DIVQ;
        end
      end
      ST_DIVQ: begin
        if (dcnt_q == 5'd17) begin
          inc_d = quo_d[15:0]; // equal share of the setpoint
          frac_d = rem_d[13:0];
          left_d = nsteps_q;
          err_d = 15'h0000;
          target_d = 16'h0000; // ramp starts from zero
          st_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (tick) begin
          left_d = left_q - 14'h0001; // one step per tick
          if (left_q == 14'h0001) begin
            target_d = setpoint_q; // last step lands exactly
            st_d = ST_SETTLE;
          end else if (esum >= {1'b0, nsteps_q}) begin
            err_d = esum - {1'b0, nsteps_q};
            target_d = target_q + inc_q + 16'h0001;
          end else begin
            err_d = esum;
            target_d = target_q + inc_q;
          end
        end
      end
      ST_SETTLE: begin
        if (uv_raw_q) begin
          st_d = ST_ON;
        end
      end
      ST_ON: st_d = ST_ON;
      default: st_d = ST_HOLD;
    endcase
    // losing the line or the input drops everything back to hold
    if (st_q != ST_HOLD && st_q != ST_RELEASE) begin
      if (!run_s2_q || !init_done || (vin_level <= vin_thr_q)) begin
        st_d = ST_HOLD;
        target_d = 16'h0000;
      end
    end
  end

  // register the sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= ST_HOLD;
      dly_q <= 18'h00000;
      num_q <= 18'h00000;
      den_q <= 18'h00001;
      quo_q <= 18'h00000;
      rem_q <= 18'h00000;
      dcnt_q <= 5'h00;
      nsteps_q <= 14'h0001;
      left_q <= 14'h0000;
      inc_q <= 16'h0000;
      frac_q <= 14'h0000;
      err_q <= 15'h0000;
      target_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      dly_q <= dly_d;
      num_q <= num_d;
      den_q <= den_d;
      quo_q <= quo_d;
      rem_q <= rem_d;
      dcnt_q <= dcnt_d;
      nsteps_q <= nsteps_d;
      left_q <= left_d;
      inc_q <= inc_d;
      frac_q <= frac_d;
      err_q <= err_d;
      target_q <= target_d;
    end
  end

  // deglitched undervoltage comparison
  sss_uv_deglitch #(
    .FILT_CYCLES(UV_FILTER_CYCLES)
  ) u_uv_deglitch (
    .mclk(mclk),
    .reset(reset),
    .raw_in(uv_raw_q),
    .filt_out(uv_filt)
  );

  // raw path is faster, filtered path rides out comparator chatter
  assign uv_src = prop_q[PROP_DEGLITCH_BIT] ? uv_filt : uv_raw_q;
  // ramp and settle force discontinuous switching
  assign dcm_force = (st_q == ST_DIVN) || (st_q == ST_DIVQ) || (st_q == ST_RAMP) ||
                     (st_q == ST_SETTLE);
  assign dcm_now = dcm_force || (op_mode_q == MODE_DCM);

  // output flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      uv_raw_q <= 1'b0;
      run_oe_q <= 1'b1;
      gpio_oe_q <= 1'b0;
      pwm_q <= MODE_DCM;
      bg_q <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      uv_raw_q <= (vout_level > uv_limit_q);
      run_oe_q <= (st_d == ST_HOLD); // pull the shared line low
      gpio_oe_q <= prop_q[PROP_UV_RELEASE_BIT] && !uv_src;
      pwm_q <= dcm_force ? MODE_DCM : op_mode_q;
      bg_q <= !(dcm_now && rev_s2_q);
      sw_q <= (st_q != ST_HOLD) && (st_q != ST_RELEASE) && (st_q != ST_DELAY);
    end
  end

  assign reg_rdata = rdata_q;
  assign run_out = 1'b0;
  assign run_oe = run_oe_q;
  assign timebase_out = 1'b0;
  assign timebase_oe = tb_oe_q;
  assign gpio_out = 1'b0;
  assign gpio_oe = gpio_oe_q;
  assign target_level = target_q;
  assign pwm_mode = pwm_q;
  assign bottom_gate_allow = bg_q;
  assign switching_en = sw_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_ramp_entry;
    (st_q == ST_DIVQ) ##1 (st_q == ST_RAMP);
  endsequence

  sequence s_last_step;
    (st_q == ST_RAMP) && tick && (left_q == 14'h0001) && run_s2_q && init_done &&
      (vin_level > vin_thr_q);
  endsequence

  a_run_held_low: assert property ((st_q == ST_HOLD) && !init_done |=> run_oe_q)
    else $error("enable line released before initialization");
  a_run_released: assert property ((st_q == ST_HOLD) && init_done && (vin_level > vin_thr_q)
    |=> !run_oe_q)
    else $error("enable line not released when ready");
  a_delay_gates: assert property ((st_q == ST_DELAY) && !tick |=> st_q inside {ST_DELAY, ST_HOLD})
    else $error("left delay without a timebase tick");
  a_tick_resync: assert property (tick |=> tb_cnt_q == 16'h0000)
    else $error("timebase did not follow shared edge");
  a_ramp_zero: assert property (s_ramp_entry |-> target_q == 16'h0000)
    else $error("ramp did not start from zero");
  a_skip_short: assert property ((st_q == ST_DELAY) && tick && (dly_q <= TICK_UNITS) &&
    (rise_eff < SOFTSTART_MIN_UNITS) && run_s2_q && init_done && (vin_level > vin_thr_q)
    |=> (st_q == ST_SETTLE) && (target_q == setpoint_q))
    else $error("short rise time did not skip the ramp");
  a_step_on_tick: assert property ((st_q == ST_RAMP) && !tick && run_s2_q && init_done &&
    (vin_level > vin_thr_q) |=> $stable(target_q))
    else $error("target moved between ticks");
  a_dcm_in_ramp: assert property ((st_q == ST_RAMP) |=> pwm_mode == MODE_DCM)
    else $error("ramp not in discontinuous mode");
  a_reverse_cut: assert property (dcm_now && rev_s2_q |=> !bottom_gate_allow)
    else $error("bottom gate kept on with reverse current");
  a_gpio_hold: assert property (prop_q[PROP_UV_RELEASE_BIT] && !uv_src |=> gpio_oe)
    else $error("gpio released while under voltage");
  a_raw_select: assert property (!prop_q[PROP_DEGLITCH_BIT] && prop_q[PROP_UV_RELEASE_BIT] &&
    uv_raw_q |=> !gpio_oe)
    else $error("raw undervoltage path not used");
  a_rise_capped: assert property (rise_eff <= RISE_CAP_UNITS)
    else $error("rise time above cap");
  a_mode_restore: assert property ((st_q == ST_ON) && $stable(op_mode_q) |=> pwm_mode == $past(op_mode_q))
    else $error("programmed mode not restored");
  a_last_exact: assert property (s_last_step |=> target_q == $past(setpoint_q))
    else $error("final step missed the setpoint");

endmodule : sss_sequencer

// [tb/sss_peer_model.sv]
// partner controller sharing the enable line and the timebase line
`timescale 1ns/1ps
module sss_peer_model #(
  parameter int unsigned PERIOD = 30
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ready,
  output logic run_oe,
  output logic tb_oe
);
  int unsigned cnt_q; // own timebase phase
  // holds the shared enable line low until its own start-up is done
  always_ff @(posedge mclk) begin
    run_oe <= reset | !ready;
  end
  // free running timebase, faster than the block so that it sets the pace
  always_ff @(posedge mclk) begin
    cnt_q <= (reset || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    tb_oe <= !reset && cnt_q < PERIOD / 2;
  end
endmodule : sss_peer_model

// [tb/tb_startup_delay_softstart_sequencer.sv]
// self-checking bench of the start-up sequencer beside one partner controller
`timescale 1ns/1ps
module tb_startup_delay_softstart_sequencer;
  import sss_pkg::*;
  logic mclk = 0;
  logic reset = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic init_done = 0;
  logic peer_ready = 0;
  logic rev_cur = 0;
  logic [15:0] vin_level = 16'h0100;
  logic [15:0] vout_level = 16'h0000;
  logic run_out, run_oe, tb_out, tb_oe, peer_run_oe, peer_tb_oe;
  logic gpio_out, gpio_oe, bottom_gate_allow, switching_en;
  logic [15:0] target_level;
  logic [1:0] pwm_mode;
  wire run_line = !(run_oe | peer_run_oe); // pulled up, wired low
  wire tb_line = !(tb_oe | peer_tb_oe); // pulled up, wired low
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;

  sss_sequencer #(.TIMEBASE_CYCLES(40), .UV_FILTER_CYCLES(8)) dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_done(init_done),
    .vin_level(vin_level), .vout_level(vout_level), .run_in(run_line),
    .run_out(run_out), .run_oe(run_oe), .timebase_in(tb_line),
    .timebase_out(tb_out), .timebase_oe(tb_oe), .reverse_current_in(rev_cur),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .target_level(target_level),
    .pwm_mode(pwm_mode), .bottom_gate_allow(bottom_gate_allow),
    .switching_en(switching_en)
  );
  sss_peer_model #(.PERIOD(30)) peer (
    .mclk(mclk), .reset(reset), .ready(peer_ready), .run_oe(peer_run_oe),
    .tb_oe(peer_tb_oe)
  );

  // 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  // hang guard, the whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cycles

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // rise time reset value, read back, rdata clearing after a read and unmapped places
  task automatic t_regs();
    logic [31:0] d;
    rd(OFS_RISE_TIME, d);
    chk("rise reset", d, 32'h0);
    wr(OFS_SETPOINT, 32'h0064);
    rd(OFS_SETPOINT, d);
    chk("setpoint", d, 32'h0064);
    cycles(1);
    chk("rdata after read", reg_rdata, 32'h0);
    wr(8'h24, 32'hffff);
    rd(8'h24, d);
    chk("unmapped", d, 32'h0);
    wr(OFS_OP_CONFIG, MODE_LIGHT_LOAD);
    wr(OFS_PIN_PROPAGATE, 32'h3);
    wr(OFS_VIN_THRESHOLD, 32'h0200);
    wr(OFS_TURN_ON_DELAY, 32'h1e);
    wr(OFS_RISE_TIME, 32'h32);
    wr(OFS_UV_LIMIT, 32'h0100);
  endtask : t_regs

  // enable line held while not ready, then left to the partner
  task automatic t_hold();
    logic [31:0] d;
    cycles(8);
    chk("run_oe no init", run_oe, 1'b1);
    chk("open drain data", {run_out, tb_out, gpio_out}, 32'h0);
    init_done <= 1'b1;
    cycles(8);
    chk("run_oe vin low", run_oe, 1'b1);
    vin_level <= 16'h0300;
    cycles(3);
    chk("run_oe ready", run_oe, 1'b0);
    cycles(100);
    rd(OFS_STATUS, d);
    chk("state partner holds", d[2:0], 3'h1);
    chk("switching partner holds", switching_en, 1'b0);
  endtask : t_hold

  // turn-on delay of three ticks, then five equal steps in discontinuous mode
  task automatic t_ramp();
    int ticks;
    int k;
    logic prev;
    logic [15:0] last;
    ticks = 0;
    k = 0;
    while (tb_line !== 1'b0) cycles(1);
    peer_ready <= 1'b1;
    prev = 1'b0;
    while (switching_en !== 1'b1 && ticks < 20) begin
      cycles(1);
      if (prev && !tb_line) ticks++;
      prev = tb_line;
    end
    chk("delay ticks", ticks, 3);
    last = 16'h0;
    for (int i = 0; i < 800 && last != 16'h0064; i++) begin
      cycles(1);
      chk("mode in ramp", pwm_mode, MODE_DCM);
      if (target_level !== last) begin
        k++;
        chk("ramp step", target_level, 20 * k);
        last = target_level;
      end
    end
    chk("step count", k, 5);
  endtask : t_ramp

  // reverse current, deglitched gpio release and programmed mode afterwards
  task automatic t_settle();
    cycles(3);
    chk("gate allowed", bottom_gate_allow, 1'b1);
    rev_cur <= 1'b1;
    cycles(5);
    chk("gate cut", bottom_gate_allow, 1'b0);
    rev_cur <= 1'b0;
    chk("gpio held", gpio_oe, 1'b1);
    vout_level <= 16'h0200;
    cycles(5);
    chk("gpio filtered", gpio_oe, 1'b1);
    chk("programmed mode", pwm_mode, MODE_LIGHT_LOAD);
    cycles(12);
    chk("gpio released", gpio_oe, 1'b0);
  endtask : t_settle

  // lost init drops back, then a short rise time jumps straight to setpoint
  task automatic t_skip();
    init_done <= 1'b0;
    vout_level <= 16'h0000;
    cycles(4);
    chk("run_oe init lost", run_oe, 1'b1);
    chk("target dropped", target_level, 16'h0);
    wr(OFS_RISE_TIME, 32'h18);
    init_done <= 1'b1;
    for (int i = 0; i < 800 && target_level === 16'h0; i++) cycles(1);
    chk("no ramp", target_level, 16'h0064);
  endtask : t_skip

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_hold();
    t_ramp();
    t_settle();
    t_skip();
    wrap_up();
  end
endmodule : tb_startup_delay_softstart_sequencer
